// ==== design/sapr_adc_readout.sv ====
`include "sapr_cfg.svh"

module sapr_adc_readout
  import sapr_pkg::*;
#(
  parameter int RES_W = `SAPR_RES_W,
  parameter int BIT_CYC = `SAPR_BIT_CYC,
  parameter int FIFO_DEPTH = `SAPR_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic convert_strobe_n,
  input wire logic device_select_n,
  input wire logic read_strobe_n,
  input wire logic byte_fold,
  input wire logic reset_powerdown_n,
  input wire logic comp_above,
  output logic busy,
  output logic [RES_W-1:0] result_bus_out,
  output logic result_bus_oe,
  output logic track_inputs,
  output logic [RES_W-1:0] dac_trial
);

  // ==========================================
  // elaboration checks
  localparam int CONV_CYC = `SAPR_CONV_CYC;

  if (RES_W != `SAPR_RES_W) begin : g_bad_width
    $error("result width must be 16 for the fold layout");
  end
  if (BIT_CYC < `SAPR_MIN_BIT_CYC) begin : g_bad_bitcyc
    $error("bit period too short for comparator sync");
  end
  if (RES_W * BIT_CYC + `SAPR_CONV_OVERHEAD > CONV_CYC) begin : g_slow
    $error("conversion cannot finish in the allowed time");
  end

  // ==========================================
  // declarations
  sapr_stream_if #(.W(RES_W)) sar_to_fifo ();
  sapr_stream_if #(.W(RES_W)) fifo_to_hold ();

  logic [`SAPR_PIN_W-1:0] pin_raw;
  logic [`SAPR_PIN_W-1:0] pin_s1_q;
  logic [`SAPR_PIN_W-1:0] pin_s2_q;
  logic [`SAPR_PIN_W-1:0] pin_s3_q;
  sapr_state_type state_q;
  sapr_word_type held_q;
  logic busy_q;
  logic track_q;
  logic bus_oe_q;
  sapr_word_type bus_q;
  logic [7:0] busy_cnt_q;
  logic conv_fall;
  logic sel_low;
  logic sel_fall;
  logic rd_low;
  logic byte_s;
  logic pd_active;
  logic fire;
  logic drive_d;
  logic pop;
  logic flush;

  // ==========================================
  // helpers
  function automatic sapr_word_type fold_word(
    input sapr_word_type w,
    input logic fold
  );
    return fold ? {w[7:2], `SAPR_FOLD_FILL} : w;
  endfunction : fold_word

  // ==========================================
  // pin synchronisers
  assign pin_raw = {reset_powerdown_n, byte_fold, read_strobe_n,
                    device_select_n, convert_strobe_n};

  always_ff @(posedge clock) begin
    if (srst) begin
      pin_s1_q <= `SAPR_PIN_IDLE;
      pin_s2_q <= `SAPR_PIN_IDLE;
      pin_s3_q <= `SAPR_PIN_IDLE;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign conv_fall = pin_s3_q[`SAPR_PIN_CONV] && !pin_s2_q[`SAPR_PIN_CONV];
  assign sel_low = !pin_s2_q[`SAPR_PIN_SEL];
  assign sel_fall = pin_s3_q[`SAPR_PIN_SEL] && sel_low;
  assign rd_low = !pin_s2_q[`SAPR_PIN_RD];
  assign byte_s = pin_s2_q[`SAPR_PIN_BYTE];
  assign pd_active = !pin_s2_q[`SAPR_PIN_PD];

  // ==========================================
  // control decode
  // start only from acquisition with select low
  // a strobe during a conversion is dropped, not queued
  assign fire = conv_fall && sel_low && !pd_active
                && state_q == ST_ACQUIRE;
  assign drive_d = sel_low && rd_low;
  // no pop while the bus is or is about to be driven
  assign fifo_to_hold.ready = state_q == ST_CONVERT && !drive_d
                              && !bus_oe_q && !pd_active;
  assign pop = fifo_to_hold.ready && fifo_to_hold.valid;
  assign flush = srst || pd_active;

  // ==========================================
  // conversion core and result buffer
  sapr_sar_engine #(.W(RES_W), .BIT_CYC(BIT_CYC)) u_engine (
    .clock(clock),
    .srst(srst),
    .start(fire),
    .abort(pd_active),
    .comp_above(comp_above),
    .trial_code(dac_trial),
    .res_s(sar_to_fifo)
  );

  sapr_fifo #(.W(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .srst(flush),
    .in_s(sar_to_fifo),
    .out_s(fifo_to_hold)
  );

  // ==========================================
  // sequencing
  always_ff @(posedge clock) begin
    if (srst || pd_active) begin
      state_q <= ST_ACQUIRE;
    end else begin
      unique case (state_q)
        ST_ACQUIRE: begin
          if (fire) begin
            state_q <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (pop) begin
            state_q <= sel_low ? ST_ACQUIRE : ST_PARKED;
          end
        end
        ST_PARKED: begin
          if (sel_fall) begin
            state_q <= ST_ACQUIRE;
          end
        end
      endcase
    end
  end

  // ==========================================
  // busy flag
  always_ff @(posedge clock) begin
    if (srst || pd_active) begin
      busy_q <= 1'b0;
    end else if (fire) begin
      busy_q <= 1'b1;
    end else if (pop) begin
      busy_q <= 1'b0;
    end
  end

  // ==========================================
  // input switch: high tracks, low holds
  always_ff @(posedge clock) begin
    if (srst || pd_active) begin
      track_q <= 1'b1;
    end else if (fire) begin
      track_q <= 1'b0;
    end else if (pop && sel_low) begin
      track_q <= 1'b1;
    end else if (state_q == ST_PARKED && sel_fall) begin
      track_q <= 1'b1;
    end
  end

  // ==========================================
  // held result
  always_ff @(posedge clock) begin
    if (srst) begin
      held_q <= '0;
    end else if (pop) begin
      held_q <= fifo_to_hold.data;
    end
  end

  // ==========================================
  // output bus
  always_ff @(posedge clock) begin
    if (srst) begin
      bus_oe_q <= 1'b0;
      bus_q <= '0;
    end else begin
      bus_oe_q <= drive_d;
      bus_q <= drive_d ? fold_word(held_q, byte_s) : '0;
    end
  end

  // ==========================================
  // conversion length monitor
  always_ff @(posedge clock) begin
    if (srst || !busy_q) begin
      busy_cnt_q <= '0;
    end else if (busy_cnt_q != 8'hFF) begin
      busy_cnt_q <= busy_cnt_q + 8'h01;
    end
  end

  assign busy = busy_q;
  assign track_inputs = track_q;
  assign result_bus_oe = bus_oe_q;
  assign result_bus_out = bus_q;

  // ==========================================
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  sequence s_start;
    fire;
  endsequence

  sequence s_read;
    sel_low && rd_low;
  endsequence

  sequence s_finish_selected;
    pop && sel_low && !pd_active;
  endsequence

  sequence s_finish_parked;
    pop && !sel_low && !pd_active;
  endsequence

  a_bus_enable: assert property (s_read |=> bus_oe_q)
    else $error("bus not enabled for a read");
  a_bus_only_read: assert property (
    bus_oe_q |-> $past(sel_low && rd_low))
    else $error("bus driven without select and read");
  a_bus_quiet: assert property (!bus_oe_q |-> bus_q == '0)
    else $error("bus value present while released");
  a_full_word: assert property (
    bus_oe_q && !$past(byte_s) |-> bus_q == $past(held_q))
    else $error("full word read differs from held result");
  a_fold_word: assert property (
    bus_oe_q && $past(byte_s)
    |-> bus_q == {$past(held_q[7:2]), `SAPR_FOLD_FILL})
    else $error("folded read has wrong layout");
  a_busy_start: assert property (s_start |=> busy_q && !track_q)
    else $error("busy or hold missing after start");
  a_conv_bound: assert property (
    busy_cnt_q <= 8'(CONV_CYC))
    else $error("conversion longer than allowed");
  a_inputs_isolated: assert property (busy_q |-> !track_q)
    else $error("inputs connected during conversion");
  a_acq_resume: assert property (
    s_finish_selected |=> track_q && !busy_q)
    else $error("acquisition did not resume at busy fall");
  a_park_release: assert property (
    state_q == ST_PARKED && sel_fall && !pd_active
    |=> track_q ##1 !busy_q)
    else $error("acquisition did not resume at select fall");
  a_held_stable: assert property (!pop |=> $stable(held_q))
    else $error("held result changed without a new result");
  a_read_stable: assert property (
    bus_oe_q && $past(bus_oe_q) && $stable(byte_s)
    && $past(byte_s) == $past(byte_s, 2) |-> $stable(bus_q))
    else $error("bus value changed during a read");

  // ==========================================
  // conversion control
  a_busy_holds: assert property (
    busy_q && !pop && !pd_active |=> busy_q)
    else $error("busy dropped before the result was taken");
  a_start_needs_sel: assert property (
    conv_fall && !sel_low && !busy_q |=> !busy_q)
    else $error("conversion started without select");
  a_busy_in_convert: assert property (
    busy_q |-> state_q == ST_CONVERT)
    else $error("busy outside a conversion");
  a_park_hold: assert property (
    s_finish_parked
    |=> !track_q && !busy_q && state_q == ST_PARKED)
    else $error("inputs reconnected without select");
  a_acq_tracks: assert property (state_q == ST_ACQUIRE |-> track_q)
    else $error("inputs held during acquisition");
  a_read_no_pop: assert property (bus_oe_q |=> $stable(held_q))
    else $error("held result replaced during a read");

endmodule : sapr_adc_readout

// ==== design/sapr_cfg.svh ====
`ifndef SAPR_CFG_SVH
`define SAPR_CFG_SVH

// ==========================================
// timing
`define SAPR_CLK_PERIOD_NS 10
`define SAPR_CONV_TIME_NS 700
`define SAPR_CONV_CYC (`SAPR_CONV_TIME_NS / `SAPR_CLK_PERIOD_NS)
`define SAPR_BIT_CYC 4
`define SAPR_MIN_BIT_CYC 4
`define SAPR_CONV_OVERHEAD 6

// ==========================================
// result word and buffering
`define SAPR_RES_W 16
`define SAPR_FIFO_DEPTH 4
`define SAPR_FOLD_FILL 10'h3FF

// ==========================================
// pin synchroniser bit positions
`define SAPR_PIN_W 5
`define SAPR_PIN_CONV 0
`define SAPR_PIN_SEL 1
`define SAPR_PIN_RD 2
`define SAPR_PIN_BYTE 3
`define SAPR_PIN_PD 4
`define SAPR_PIN_IDLE 5'h17

`endif

// ==== design/sapr_fifo.sv ====
module sapr_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic srst,
  sapr_stream_if.snk in_s,
  sapr_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty = wr_q == rd_q;
  assign push = in_s.valid && !full;
  assign pop = out_s.ready && !empty;
  assign in_s.ready = !full;
  assign out_s.valid = !empty;
  assign out_s.data = mem[rd_q[AW-1:0]];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_s.data;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  a_fifo_fill: assert property (@(posedge clock) disable iff (srst)
    push && !pop |=> (wr_q - rd_q) == $past(wr_q - rd_q) + 1'b1)
    else $error("fifo fill count wrong");
  a_fifo_order: assert property (@(posedge clock) disable iff (srst)
    push && empty |=> out_s.data == $past(in_s.data))
    else $error("fifo head not the first word written");
endmodule : sapr_fifo

// ==== design/sapr_pkg.sv ====
`include "sapr_cfg.svh"

package sapr_pkg;

  typedef logic [`SAPR_RES_W-1:0] sapr_word_type;

  typedef enum logic [1:0] {
    ST_ACQUIRE,
    ST_CONVERT,
    ST_PARKED
  } sapr_state_type;

endpackage : sapr_pkg

// ==== design/sapr_sar_engine.sv ====
module sapr_sar_engine #(
  parameter int W = 16,
  parameter int BIT_CYC = 4
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic start,
  input wire logic abort,
  input wire logic comp_above,
  output logic [W-1:0] trial_code,
  sapr_stream_if.src res_s
);
  localparam int CW = $clog2(BIT_CYC);
  localparam int BW = $clog2(W);

  logic cmp_s1_q;
  logic cmp_s2_q;
  logic run_q;
  logic valid_q;
  logic [CW-1:0] cyc_q;
  logic [BW-1:0] bit_q;
  logic [W-1:0] code_q;
  logic last;

  assign last = cyc_q == CW'(BIT_CYC - 1);
  assign trial_code = code_q;
  assign res_s.valid = valid_q;
  assign res_s.data = code_q;

  // ==========================================
  // comparator synchroniser
  always_ff @(posedge clock) begin
    if (srst) begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else begin
      cmp_s1_q <= comp_above;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  // ==========================================
  // bit-by-bit approximation
  always_ff @(posedge clock) begin
    if (srst || abort) begin
      run_q <= 1'b0;
      valid_q <= 1'b0;
      cyc_q <= '0;
      bit_q <= '0;
      code_q <= '0;
    end else if (start) begin
      run_q <= 1'b1;
      valid_q <= 1'b0;
      cyc_q <= '0;
      bit_q <= BW'(W - 1);
      code_q <= {1'b1, {(W-1){1'b0}}};
    end else if (run_q) begin
      cyc_q <= last ? '0 : cyc_q + 1'b1;
      if (last) begin
        if (!cmp_s2_q) begin
          code_q[bit_q] <= 1'b0;
        end
        if (bit_q == '0) begin
          run_q <= 1'b0;
          valid_q <= 1'b1;
        end else begin
          code_q[bit_q - 1'b1] <= 1'b1;
          bit_q <= bit_q - 1'b1;
        end
      end
    end else if (valid_q && res_s.ready) begin
      valid_q <= 1'b0;
    end
  end

  a_trial_msb: assert property (@(posedge clock) disable iff (srst)
    start && !abort |=> code_q == {1'b1, {(W-1){1'b0}}} && run_q)
    else $error("conversion did not start at mid-scale");
  a_last_bit: assert property (@(posedge clock) disable iff (srst)
    run_q && last && bit_q == '0 && !start && !abort
    |=> valid_q && !run_q)
    else $error("final bit did not present a result");
endmodule : sapr_sar_engine

// ==== design/sapr_stream_if.sv ====
interface sapr_stream_if #(parameter int W = 16) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sapr_stream_if

// ==== verification/sapr_host_model.sv ====
module sapr_host_model
  import sapr_pkg::*;
(
  input wire logic clock,
  input wire logic busy,
  input wire logic [15:0] result_bus_out,
  input wire logic result_bus_oe,
  output logic convert_strobe_n,
  output logic device_select_n,
  output logic read_strobe_n,
  output logic byte_fold
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    convert_strobe_n = 1'b1;
    device_select_n = 1'b1;
    read_strobe_n = 1'b1;
    byte_fold = 1'b0;
  end

  // ==========================================
  // pin cycles
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  // up: edges until busy rose, hi: cycles busy stayed high
  task automatic convert(input logic sel_n, output int up, output int hi);
    up = 0;
    hi = 0;
    device_select_n = sel_n;
    convert_strobe_n = 1'b0;
    step(2);
    convert_strobe_n = 1'b1;
    while (busy !== 1'b1 && up < 10) begin
      step(1);
      up++;
    end
    // result fetched only after busy falls
    while (busy === 1'b1 && hi < 100) begin
      step(1);
      hi++;
    end
    device_select_n = 1'b1;
    step(6); // quiet zone kept before any read
  endtask : convert

  // select raised once the strobe is seen: result waits parked
  task automatic convert_parked(output int hi);
    hi = 0;
    device_select_n = 1'b0;
    convert_strobe_n = 1'b0;
    step(2);
    convert_strobe_n = 1'b1;
    device_select_n = 1'b1;
    step(2);
    while (busy === 1'b1 && hi < 100) begin
      step(1);
      hi++;
    end
  endtask : convert_parked

  // one read strobe pulse per access, select as chip enable
  task automatic read(input logic fold, input logic sel_n,
                      output sapr_word_type d, output logic ok);
    int n;
    n = 0;
    byte_fold = fold;
    device_select_n = sel_n;
    read_strobe_n = 1'b0;
    while (result_bus_oe !== 1'b1 && n < 8) begin
      step(1);
      n++;
    end
    ok = (n < 8);
    d = result_bus_out;
    step(1);
    read_strobe_n = 1'b1;
    device_select_n = 1'b1;
    step(5);
  endtask : read
endmodule : sapr_host_model

// ==== verification/test_sar_adc_parallel_readout.sv ====
module test_sar_adc_parallel_readout
  import sapr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'b0;
  logic srst = 1'b1;
  logic conv_n, sel_n, rd_n, fold;
  logic reset_powerdown_n = 1'b1;
  logic comp_above, busy, oe, track_inputs, ok;
  sapr_word_type bus, dac_trial, vin, held_q, d;
  int n_fail = 0;
  int n_tests = 0;
  int up, hi;
  // fold, input level, expected bus word
  logic [32:0] rows [6] = '{{1'b0, 16'hFFFF, 16'hFFFF},
                            {1'b0, 16'h0000, 16'h0000},
                            {1'b0, 16'h8000, 16'h8000},
                            {1'b0, 16'h7FFF, 16'h7FFF},
                            {1'b1, 16'hA5C3, 16'hC3FF},
                            {1'b1, 16'h00FC, 16'hFFFF}};

  always #5 clock = ~clock;

  // ==========================================
  // analog side: sampled charge held while inputs isolated
  initial vin = 16'h0000;
  always_ff @(posedge clock) begin
    if (track_inputs === 1'b1) held_q <= vin;
  end
  assign comp_above = (held_q >= dac_trial);

  sapr_adc_readout sapr_adc_readout_inst (
    .clock(clock), .srst(srst), .convert_strobe_n(conv_n),
    .device_select_n(sel_n), .read_strobe_n(rd_n), .byte_fold(fold),
    .reset_powerdown_n(reset_powerdown_n), .comp_above(comp_above),
    .busy(busy), .result_bus_out(bus), .result_bus_oe(oe),
    .track_inputs(track_inputs), .dac_trial(dac_trial)
  );

  sapr_host_model sapr_host_model_inst (
    .clock(clock), .busy(busy), .result_bus_out(bus),
    .result_bus_oe(oe), .convert_strobe_n(conv_n),
    .device_select_n(sel_n), .read_strobe_n(rd_n), .byte_fold(fold)
  );

  // ==========================================
  // checking and closing
  task automatic check(input logic good, input string msg);
    n_tests++;
    if (good !== 1'b1) begin
      n_fail++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask : check

  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  task automatic conv_read(input logic f);
    sapr_host_model_inst.convert(1'b0, up, hi);
    check(up < 10, "busy did not rise");
    check(hi > 0 && hi <= 70, "conversion time");
    if (hi >= 100) results();
    sapr_host_model_inst.read(f, 1'b0, d, ok);
    if (ok !== 1'b1) check(1'b0, "bus never enabled");
    if (ok !== 1'b1) results();
  endtask : conv_read

  initial begin
    repeat (12) @(posedge clock);
    #1;
    srst = 1'b0;
    check(busy === 1'b0 && oe === 1'b0 && bus === 16'h0000, "reset");
    check(track_inputs === 1'b1, "reset track");
    sapr_host_model_inst.step(3);
    for (int i = 0; i < 6; i++) begin
      vin = rows[i][31:16];
      conv_read(rows[i][32]);
      check(d === rows[i][15:0], "result word");
      check(dac_trial === rows[i][31:16], "final trial code");
      check(oe === 1'b0 && bus === 16'h0000, "bus not released");
      sapr_host_model_inst.read(rows[i][32], 1'b0, d, ok);
      check(ok === 1'b1 && d === rows[i][15:0], "result not held");
      check(track_inputs === 1'b1, "not acquiring");
      $display("row %0d done", i);
    end
    // strobe with select high is ignored
    sapr_host_model_inst.convert(1'b1, up, hi);
    check(up == 10 && hi == 0, "start without select");
    // read strobe alone leaves bus off
    sapr_host_model_inst.read(1'b0, 1'b1, d, ok);
    check(ok === 1'b0 && d === 16'h0000, "bus driven unselected");
    $display("select tests done");
    // input change during conversion must not reach the result
    vin = 16'h1234;
    fork
      conv_read(1'b0);
      begin
        repeat (10) @(posedge clock);
        #1;
        check(busy === 1'b1 && track_inputs === 1'b0, "not isolated");
        vin = 16'hEDCB;
      end
    join
    check(d === 16'h1234, "sample not taken at start");
    $display("isolation test done");
    // power-down mid conversion aborts, keeps previous result
    vin = 16'h4321;
    fork
      sapr_host_model_inst.convert(1'b0, up, hi);
      begin
        repeat (20) @(posedge clock);
        #1;
        reset_powerdown_n = 1'b0;
        repeat (8) @(posedge clock);
        #1;
        reset_powerdown_n = 1'b1;
      end
    join
    check(hi > 0 && hi < 30, "abort did not end busy");
    sapr_host_model_inst.step(4);
    sapr_host_model_inst.read(1'b0, 1'b0, d, ok);
    check(ok === 1'b1 && d === 16'h1234, "held result lost");
    $display("power-down test done");
    // select raised during conversion: inputs held until select falls
    vin = 16'h5A5A;
    sapr_host_model_inst.convert_parked(hi);
    check(hi > 0 && hi <= 70, "parked conversion time");
    check(busy === 1'b0 && track_inputs === 1'b0, "inputs not held");
    sapr_host_model_inst.read(1'b0, 1'b0, d, ok);
    check(ok === 1'b1 && d === 16'h5A5A, "parked result");
    check(track_inputs === 1'b1, "no acquire at select fall");
    $display("park test done");
    results();
  end
endmodule : test_sar_adc_parallel_readout
